// [verilog/rpc_top.sv]
// The address map and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module rpc_top #(
  parameter int PWR_CYC = rpc_pkg::PWR_STAB_CYC,
  parameter int DEB_CYC = rpc_pkg::DEB_CYC
) (
  input wire logic hclk, // bus clock 20 mhz
  input wire logic hresetn, // async reset, low
  input wire logic hsel, // slave select
  input wire logic [7:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write phase
  input wire logic [2:0] hsize, // word only
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic [31:0] hrdata, // read data
  output logic hreadyout, // always ready
  output logic hresp, // always okay
  input wire logic lvd_low, // comparator, vdd at or below 1.8 v
  input wire logic shared_reset_pin, // shared reset pin level
  input wire logic slow_osc, // internal slow oscillator
  input wire logic fast_osc, // selected cpu clock source
  input wire rpc_pkg::rpc_cpu_mode_t cpu_mode, // cpu operating mode
  output logic sys_reset_n, // system reset, low
  output logic osc_start, // start cpu clock source
  output logic [1:0] clk_src, // loaded clock source
  output logic pin_is_gpio, // pin free for gpio
  output logic [15:0] fetch_addr // first fetch address
);
  // assertion clock and reset for the whole module
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  ////////////////////////////////////////////////////////////////
  // pin synchronisers: lvd, pin, slow, fast; reset to idle levels, no false event
  logic [3:0] s1_r, s2_r, s3_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_r <= 4'h7;
      s2_r <= 4'h7;
      s3_r <= 4'h7;
    end else begin
      s1_r <= {lvd_low, shared_reset_pin, slow_osc, fast_osc};
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  wire lvd_s = s2_r[3];
  wire pin_low_s = !s2_r[2];
  wire slow_tick = s2_r[1] && !s3_r[1];
  wire fast_tick = s2_r[0] && !s3_r[0];

  ////////////////////////////////////////////////////////////////
  // registers
  rpc_pkg::rpc_state_t state_r, state_nxt;
  rpc_pkg::rpc_cfg_t cfg_r;
  logic [7:0] flags_r;
  logic soft_flag_r, soft_reset_control_armed_r;
  logic [23:0] cnt_r, deb_cnt_r;
  logic [4:0] pre_cnt_r;
  logic [7:0] wdt_cnt_r;
  logic wr_pend_r;
  logic [7:0] wr_addr_r;

  // watchdog prescaler terminal count
  function automatic logic [4:0] pre_last(input logic [1:0] sel);
    logic [5:0] d;
    d = 6'd4 << sel;
    return 5'(d - 6'd1);
  endfunction

  ////////////////////////////////////////////////////////////////
  // bus decode
  wire ahb_sel = hsel && htrans[1] && hready;
  wire wr_now = wr_pend_r && hready;
  wire wclr_hit = wr_now && wr_addr_r == rpc_pkg::OFS_WCLR && hwdata[7:0] == rpc_pkg::WCLR_KEY;
  wire soft_reset_control_wr = wr_now && wr_addr_r == rpc_pkg::OFS_SOFT_RESET_CONTROL;
  wire soft_reset_control_set = soft_reset_control_wr && hwdata[rpc_pkg::SOFT_RESET_CONTROL_REQ_BIT];
  wire cfg_wr = wr_now && wr_addr_r == rpc_pkg::OFS_CFG;
  wire soft_fire = soft_reset_control_set && soft_reset_control_armed_r && state_r == rpc_pkg::ST_RUN;
  wire [7:0] rd_byte =
    haddr == rpc_pkg::OFS_FLAGS ? {flags_r[7:5], 5'h00} :
    haddr == rpc_pkg::OFS_SOFT_RESET_CONTROL ? {7'h00, soft_flag_r} :
    haddr == rpc_pkg::OFS_CFG ? cfg_r : 8'h00;

  ////////////////////////////////////////////////////////////////
  // reset sources
  wire pin_fast = cfg_r.pin == rpc_pkg::PIN_RST && pin_low_s;
  wire deb_hit = deb_cnt_r == 24'(DEB_CYC - 1);
  wire pin_deb = cfg_r.pin == rpc_pkg::PIN_RST_DEB && pin_low_s && deb_hit;
  wire pin_rst = pin_fast || pin_deb;
  wire wdt_run = state_r == rpc_pkg::ST_RUN &&
    (cfg_r.wdt == rpc_pkg::WDT_ALWAYS ||
     (cfg_r.wdt == rpc_pkg::WDT_EN && cpu_mode == rpc_pkg::MODE_NORMAL));
  wire pre_wrap = slow_tick && pre_cnt_r == pre_last(cfg_r.pre);
  wire wdt_fire = wdt_run && pre_wrap &&
    wdt_cnt_r == 8'(rpc_pkg::WDT_TICKS - 1) && !wclr_hit;
  wire hard_src = lvd_s || pin_rst || wdt_fire;

  ////////////////////////////////////////////////////////////////
  // power-on sequencer next state
  wire pwr_done = cnt_r == 24'(PWR_CYC - 1);
  wire fast_done = fast_tick && cnt_r == 24'(rpc_pkg::CLK_STAB_FAST - 1);
  wire slow_done = slow_tick && cnt_r == 24'(rpc_pkg::CLK_STAB_SLOW - 1);
  always_comb begin
    state_nxt = state_r;
    if (hard_src) begin
      state_nxt = rpc_pkg::ST_HOLD;
    end else begin
      case (state_r)
        rpc_pkg::ST_HOLD: state_nxt = rpc_pkg::ST_PWR;
        rpc_pkg::ST_PWR: if (pwr_done) state_nxt = rpc_pkg::ST_FAST;
        rpc_pkg::ST_FAST: if (fast_done) state_nxt = rpc_pkg::ST_SLOW;
        rpc_pkg::ST_SLOW: if (slow_done) state_nxt = rpc_pkg::ST_RUN;
        rpc_pkg::ST_RUN: state_nxt = rpc_pkg::ST_RUN;
        default: state_nxt = rpc_pkg::ST_HOLD;
      endcase
    end
  end
  wire cnt_step = (state_r == rpc_pkg::ST_PWR) ||
    (state_r == rpc_pkg::ST_FAST && fast_tick) || (state_r == rpc_pkg::ST_SLOW && slow_tick);
  wire [23:0] cnt_nxt = (state_nxt != state_r) ? 24'h000000 :
    cnt_step ? cnt_r + 24'h000001 : cnt_r;

  // sequencer and outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= rpc_pkg::ST_PWR;
      cnt_r <= 24'h000000;
      sys_reset_n <= 1'b0;
      osc_start <= 1'b0;
      clk_src <= 2'b00;
      pin_is_gpio <= 1'b1;
      fetch_addr <= rpc_pkg::RESET_VECTOR;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      // soft reset pulses the core for one cycle, no sequence
      sys_reset_n <= state_nxt == rpc_pkg::ST_RUN && !soft_fire;
      osc_start <= state_nxt inside {rpc_pkg::ST_FAST, rpc_pkg::ST_SLOW, rpc_pkg::ST_RUN};
      if (state_r == rpc_pkg::ST_PWR && state_nxt == rpc_pkg::ST_FAST) begin
        clk_src <= cfg_r.clk_src;
      end
      pin_is_gpio <= cfg_r.pin == rpc_pkg::PIN_GPIO;
      fetch_addr <= rpc_pkg::RESET_VECTOR;
    end
  end

  ////////////////////////////////////////////////////////////////
  // de-bounce counter, restarts on any high level
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      deb_cnt_r <= 24'h000000;
    end else if (!pin_low_s) begin
      deb_cnt_r <= 24'h000000;
    end else if (!deb_hit) begin
      deb_cnt_r <= deb_cnt_r + 24'h000001;
    end
  end

  ////////////////////////////////////////////////////////////////
  // watchdog timer
  wire wdt_clr = wclr_hit || state_r != rpc_pkg::ST_RUN || soft_fire;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_cnt_r <= 5'h00;
      wdt_cnt_r <= 8'h00;
    end else if (wdt_clr) begin
      pre_cnt_r <= 5'h00;
      wdt_cnt_r <= 8'h00;
    end else if (wdt_run && slow_tick) begin
      pre_cnt_r <= pre_wrap ? 5'h00 : pre_cnt_r + 5'h01;
      if (pre_wrap) begin
        wdt_cnt_r <= wdt_cnt_r + 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // cause flags and soft reset arming
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags_r <= rpc_pkg::FLAGS_RST;
      soft_flag_r <= 1'b0;
      soft_reset_control_armed_r <= 1'b0;
    end else begin
      if (lvd_s) begin
        flags_r <= 8'(1 << rpc_pkg::FLAG_LVD_BIT);
        soft_flag_r <= 1'b0;
      end else if (wdt_fire) begin
        flags_r <= 8'(1 << rpc_pkg::FLAG_WDT_BIT);
        soft_flag_r <= 1'b0;
      end else if (pin_rst) begin
        flags_r <= 8'(1 << rpc_pkg::FLAG_PIN_BIT);
        soft_flag_r <= 1'b0;
      end else if (soft_fire) begin
        flags_r <= 8'h00;
        soft_flag_r <= 1'b1;
      end
      if (soft_fire || hard_src) begin
        soft_reset_control_armed_r <= 1'b0;
      end else if (soft_reset_control_wr) begin
        soft_reset_control_armed_r <= soft_reset_control_set;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // ahb slave, zero wait, okay always
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      cfg_r <= rpc_pkg::rpc_cfg_t'(rpc_pkg::CFG_RST);
    end else begin
      if (hready) begin
        wr_pend_r <= ahb_sel && hwrite;
        wr_addr_r <= haddr;
      end
      if (ahb_sel && !hwrite) begin
        hrdata <= {24'h000000, rd_byte};
      end
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (cfg_wr) begin
        cfg_r <= rpc_pkg::rpc_cfg_t'(hwdata[7:0]);
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // assertions
  localparam int FAST_LAST = rpc_pkg::CLK_STAB_FAST - 1;

  property p_lvd_reset;
    lvd_s |=> !sys_reset_n ##1 (state_r == rpc_pkg::ST_HOLD || !sys_reset_n);
  endproperty
  a_lvd_reset: assert property (p_lvd_reset) else $error("lvd did not reset");

  property p_pwr_no_clk;
    state_r inside {rpc_pkg::ST_HOLD, rpc_pkg::ST_PWR} |=> !osc_start || state_r != rpc_pkg::ST_PWR;
  endproperty
  a_pwr_no_clk: assert property (p_pwr_no_clk) else $error("clock on in power wait");

  property p_pwr_len;
    state_r == rpc_pkg::ST_PWR ##1 state_r == rpc_pkg::ST_FAST |-> $past(cnt_r) == 24'(PWR_CYC - 1);
  endproperty
  a_pwr_len: assert property (p_pwr_len) else $error("power wait length wrong");

  property p_fast_len;
    state_r == rpc_pkg::ST_FAST ##1 state_r == rpc_pkg::ST_SLOW |-> $past(cnt_r) == 24'(FAST_LAST);
  endproperty
  a_fast_len: assert property (p_fast_len) else $error("clock count wrong");

  property p_wdt_clr;
    wclr_hit |=> wdt_cnt_r == 8'h00 && pre_cnt_r == 5'h00;
  endproperty
  a_wdt_clr: assert property (p_wdt_clr) else $error("watchdog not cleared");

  property p_wdt_dis;
    cfg_r.wdt == rpc_pkg::WDT_DIS |-> !wdt_fire;
  endproperty
  a_wdt_dis: assert property (p_wdt_dis) else $error("disabled watchdog fired");

  property p_wdt_idle;
    cfg_r.wdt == rpc_pkg::WDT_EN && cpu_mode != rpc_pkg::MODE_NORMAL && !wclr_hit
      && !soft_fire && state_r == rpc_pkg::ST_RUN |=> $stable(wdt_cnt_r) && !$past(wdt_fire);
  endproperty
  a_wdt_idle: assert property (p_wdt_idle) else $error("watchdog ran in idle");

  property p_wdt_flag;
    wdt_fire && !lvd_s |=> flags_r[rpc_pkg::FLAG_WDT_BIT] && !sys_reset_n;
  endproperty
  a_wdt_flag: assert property (p_wdt_flag) else $error("watchdog flag missing");

  property p_soft_two;
    soft_fire && !hard_src |=> !sys_reset_n && soft_flag_r ##1
      state_r == rpc_pkg::ST_RUN || $past(hard_src);
  endproperty
  a_soft_two: assert property (p_soft_two) else $error("soft reset ran sequence");

  property p_soft_reset_control_clear;
    soft_reset_control_wr && !soft_reset_control_set |=> !soft_reset_control_armed_r;
  endproperty
  a_soft_reset_control_clear: assert property (p_soft_reset_control_clear) else $error("arming not restarted");

  property p_pin_fast;
    cfg_r.pin == rpc_pkg::PIN_RST && pin_low_s |=> !sys_reset_n;
  endproperty
  a_pin_fast: assert property (p_pin_fast) else $error("pin low without reset");

  property p_pin_deb;
    cfg_r.pin == rpc_pkg::PIN_RST_DEB && !deb_hit |-> !pin_rst;
  endproperty
  a_pin_deb: assert property (p_pin_deb) else $error("short pulse caused reset");

  c_soft: cover property (soft_fire);
  c_wdt: cover property (wdt_fire);
  c_deb: cover property (pin_deb);
  c_run: cover property (state_r == rpc_pkg::ST_SLOW ##1 state_r == rpc_pkg::ST_RUN);
endmodule
`default_nettype wire

// [inc/rpc_pkg.sv]
package rpc_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_FLAGS = 8'h00;
  localparam logic [7:0] OFS_SOFT_RESET_CONTROL = 8'h04;
  localparam logic [7:0] OFS_WCLR = 8'h08;
  localparam logic [7:0] OFS_CFG = 8'h0c;
  // field positions
  localparam int FLAG_LVD_BIT = 7;
  localparam int FLAG_WDT_BIT = 6;
  localparam int FLAG_PIN_BIT = 5;
  localparam int SOFT_RESET_CONTROL_REQ_BIT = 0;
  // reset values and keys
  localparam logic [7:0] FLAGS_RST = 8'h80;
  localparam logic [7:0] CFG_RST = 8'h01;
  localparam logic [7:0] WCLR_KEY = 8'h5a;
  localparam logic [15:0] RESET_VECTOR = 16'h0000;
  // timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int PWR_STAB_NS = 4600000;
  localparam int DEB_NS = 8000000;
  localparam int PWR_STAB_CYC = (PWR_STAB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEB_CYC = (DEB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CLK_STAB_FAST = 2048;
  localparam int CLK_STAB_SLOW = 5;
  localparam int WDT_TICKS = 256;
  // modes and states
  typedef enum logic [1:0] {WDT_DIS, WDT_EN, WDT_ALWAYS} rpc_wdt_mode_t;
  typedef enum logic [1:0] {PIN_GPIO, PIN_RST, PIN_RST_DEB} rpc_pin_mode_t;
  typedef enum logic [1:0] {MODE_NORMAL, MODE_IDLE, MODE_STOP} rpc_cpu_mode_t;
  typedef enum logic [2:0] {ST_HOLD, ST_PWR, ST_FAST, ST_SLOW, ST_RUN} rpc_state_t;
  // configuration register layout
  typedef struct packed {
    logic [1:0] clk_src;
    rpc_pin_mode_t pin;
    logic [1:0] pre;
    rpc_wdt_mode_t wdt;
  } rpc_cfg_t;
endpackage

// [testbench/tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  localparam int PWR = 20;
  localparam int DEB = 10;
  localparam logic [7:0] FL = rpc_pkg::OFS_FLAGS;
  localparam logic [7:0] SR = rpc_pkg::OFS_SOFT_RESET_CONTROL;
  localparam logic [7:0] WC = rpc_pkg::OFS_WCLR;
  localparam logic [7:0] CF = rpc_pkg::OFS_CFG;
  logic hclk, hresetn, hsel, hwrite, lvd_low, shared_reset_pin;
  logic slow_osc = 1'b0, fast_osc = 1'b0;
  logic [7:0] haddr;
  logic [1:0] htrans, clk_src, pre, cs;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rd;
  logic hreadyout, hresp, sys_reset_n, osc_start, pin_is_gpio;
  logic [15:0] fetch_addr;
  rpc_pkg::rpc_cpu_mode_t cpu_mode;
  int failures = 0;
  int n_compared = 0;
  int low_cnt = 0;
  int early, t, mg, b;

  rpc_top #(.PWR_CYC(PWR), .DEB_CYC(DEB)) i_rpc_top (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .lvd_low(lvd_low),
    .shared_reset_pin(shared_reset_pin), .slow_osc(slow_osc), .fast_osc(fast_osc),
    .cpu_mode(cpu_mode), .sys_reset_n(sys_reset_n), .osc_start(osc_start),
    .clk_src(clk_src), .pin_is_gpio(pin_is_gpio), .fetch_addr(fetch_addr)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // bus clock, 50 ns period
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  // oscillators as data; the fast source stays still until enabled
  always @(posedge hclk) begin
    slow_osc <= ~slow_osc;
    fast_osc <= osc_start ? ~fast_osc : 1'b0;
    if (sys_reset_n === 1'b0) low_cnt <= low_cnt + 1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // verdict and end of run
  task automatic finish_test();
    $display("compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t %s: got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic rng(input int v, input int lo, input int hi, input string m);
    n_compared++;
    if (v < lo || v > hi) begin
      failures++;
      $display("MISMATCH t=%0t %s: %0d not in %0d..%0d", $time, m, v, lo, hi);
    end
  endtask

  // wait for ready at a rising edge, bounded
  task automatic hs();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) begin
      failures++;
      $display("MISMATCH t=%0t bus wait timed out", $time);
      finish_test();
    end
  endtask

  // one single word transfer: address phase, then data phase
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    hsize <= 3'b010;
    hs();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    hs();
    rd = hrdata;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string m);
    bus(a, 1'b0, 32'h0);
    chk(32'(hresp), 32'h0, "response okay");
    chk(rd, exp, m);
  endtask

  // cfg word: pin 0 gpio 1 reset 2 debounce; wdt 0 off 1 enable 2 always
  function automatic logic [31:0] cfgv(input logic [1:0] pin, input logic [1:0] pr,
                                       input logic [1:0] wd);
    return {26'h0, pin, pr, wd};
  endfunction

  // wait until sys_reset_n reaches lvl, bounded; watches early clock start
  task automatic wait_lvl(input logic lvl, input int lo, input int hi, input string m);
    int c;
    c = 0;
    while (sys_reset_n !== lvl && c <= hi) begin
      @(posedge hclk);
      c++;
      if (c < PWR - 1 && osc_start !== 1'b0) early++;
    end
    rng(c, lo, hi, m);
    if (c > hi) finish_test();
  endtask

  task automatic wait_run(input string m);
    early = 0;
    wait_lvl(1'b1, PWR + 4100, PWR + 4160, m); // sequence length
    chk(32'(early), 32'h0, "clock started early"); // power wait
    chk(32'(osc_start), 32'h1, "clock source off"); // source on
    chk(32'(fetch_addr), 32'(rpc_pkg::RESET_VECTOR), "fetch address"); // vector
  endtask

  task automatic no_rst(input int n, input string m);
    b = low_cnt;
    repeat (n) @(posedge hclk);
    chk(32'(low_cnt - b), 32'h0, m);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    lvd_low = 1'b0;
    shared_reset_pin = 1'b1;
    cpu_mode = rpc_pkg::MODE_NORMAL;
    void'($urandom(32'h89d5ec28));
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    wait_run("power-on"); // power-on
    chk(32'(clk_src), 32'(rpc_pkg::CFG_RST) >> 6, "clk_src"); // loaded
    rdc(FL, 32'h80, "flags power-on"); // lvd cause
    rdc(CF, 32'(rpc_pkg::CFG_RST), "cfg reset");
    rdc(SR, 32'h0, "soft flag power-on"); // soft bit
    bus(FL, 1'b1, 32'hff);
    rdc(FL, 32'h80, "flags read-only"); // flags
    rdc(WC, 32'h0, "clear reads zero"); // clear
    rdc(8'h10, 32'h0, "unmapped");
    $display("test registers done");
    bus(CF, 1'b1, cfgv(2'h0, 2'h0, 2'h0));
    lvd_low <= 1'b1;
    wait_lvl(1'b0, 1, 4, "lvd assert"); // low supply
    repeat (30) @(posedge hclk);
    chk(32'(sys_reset_n), 32'h0, "lvd hold"); // held
    lvd_low <= 1'b0;
    wait_run("lvd run"); // lvd sequence
    rdc(FL, 32'h80, "lvd flag"); // lvd cause
    $display("test lvd done");
    bus(CF, 1'b1, cfgv(2'h0, 2'h0, 2'h0));
    shared_reset_pin <= 1'b0;
    no_rst(30, "gpio pin"); // gpio mode
    chk(32'(pin_is_gpio), 32'h1, "gpio flag"); // gpio mode
    shared_reset_pin <= 1'b1;
    bus(CF, 1'b1, cfgv(2'h1, 2'h0, 2'h0));
    repeat (2) @(posedge hclk);
    chk(32'(pin_is_gpio), 32'h0, "reset pin flag"); // pin mode
    shared_reset_pin <= 1'b0;
    wait_lvl(1'b0, 1, 5, "pin assert"); // immediate
    repeat (30) @(posedge hclk);
    chk(32'(sys_reset_n), 32'h0, "pin hold"); // held
    shared_reset_pin <= 1'b1;
    wait_run("pin run"); // pin sequence
    rdc(FL, 32'h20, "pin flag"); // pin cause
    bus(CF, 1'b1, cfgv(2'h2, 2'h0, 2'h0));
    shared_reset_pin <= 1'b0;
    repeat (DEB - 2) @(posedge hclk);
    shared_reset_pin <= 1'b1;
    no_rst(20, "short press"); // debounce
    shared_reset_pin <= 1'b0;
    wait_lvl(1'b0, DEB, DEB + 6, "debounced assert"); // debounce
    shared_reset_pin <= 1'b1;
    wait_run("debounce run");
    rdc(FL, 32'h20, "debounce flag"); // pin cause
    $display("test pin done");
    bus(CF, 1'b1, cfgv(2'h0, 2'h0, 2'h0));
    no_rst(4200, "watchdog off"); // disabled
    bus(CF, 1'b1, cfgv(2'h0, 2'h0, 2'h1));
    bus(WC, 1'b1, 32'h5a);
    cpu_mode <= rpc_pkg::MODE_IDLE;
    no_rst(4200, "enable idle"); // paused
    cpu_mode <= rpc_pkg::MODE_STOP;
    no_rst(2100, "enable stop"); // paused
    cpu_mode <= rpc_pkg::MODE_NORMAL;
    wait_lvl(1'b0, 1980, 2070, "enable expiry"); // interval
    wait_run("watchdog run"); // watchdog sequence
    rdc(FL, 32'h40, "watchdog flag"); // watchdog cause
    pre = 2'($urandom);
    t = 512 * (4 << pre);
    mg = 2 * (4 << pre) + 20;
    cs = 2'(1 + $urandom % 3);
    bus(CF, 1'b1, cfgv(2'h0, pre, 2'h2) | {24'h0, cs, 6'h00});
    bus(WC, 1'b1, 32'h5a);
    cpu_mode <= ($urandom % 2) ? rpc_pkg::MODE_IDLE : rpc_pkg::MODE_STOP;
    repeat (2) begin
      no_rst(t / 2, "cleared in time"); // key clears
      bus(WC, 1'b1, 32'h5a);
    end
    no_rst(t / 2, "cleared in time"); // prescale
    bus(WC, 1'b1, {24'($urandom), 8'h5a ^ 8'(1 + $urandom % 255)});
    wait_lvl(1'b0, t / 2 - mg, t / 2 + mg, "always expiry"); // wrong key
    cpu_mode <= rpc_pkg::MODE_NORMAL;
    wait_run("always run");
    chk(32'(clk_src), 32'(cs), "clk_src reload"); // loaded
    rdc(FL, 32'h40, "always flag"); // watchdog cause
    $display("test watchdog done");
    bus(CF, 1'b1, cfgv(2'h0, 2'h0, 2'h0));
    bus(SR, 1'b1, 32'h1);
    bus(SR, 1'b1, 32'h0);
    bus(SR, 1'b1, 32'h1);
    no_rst(5, "broken pair"); // restart count
    rdc(FL, 32'h40, "flags between");
    b = low_cnt;
    bus(SR, 1'b1, 32'h1);
    repeat (3) @(posedge hclk);
    chk(32'(low_cnt - b), 32'h1, "soft pulse"); // two writes
    chk(32'(sys_reset_n), 32'h1, "no sequence"); // no power-on
    chk(32'(clk_src), 32'(cs), "soft keeps source"); // no reload
    chk(32'(fetch_addr), 32'(rpc_pkg::RESET_VECTOR), "soft vector"); // vector
    rdc(SR, 32'h1, "soft flag"); // soft cause
    rdc(FL, 32'h0, "flags after soft"); // hard flags
    $display("test soft done");
    finish_test();
  end
endmodule
`default_nettype wire
